//--- bench/pcd_mgr_model.sv
/*
 * port manager model: register writes and reads on the decoder's
 * register port, one-cycle strobes launched at the falling edge.
 * assumes the bench clock and registered read data.
 */
module pcd_mgr_model
    import pcd_pkg::*;
(
    // clock and read data
    input wire logic CORE_CLK,
    input wire logic [7:0] REG_RDATA,
    // register port strobes
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle port at time zero
    initial
    begin
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
    end

    // one write, taken on the rising edge in between
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge CORE_CLK);
        REG_WR = 1'b1;
        REG_ADDR = addr;
        REG_WDATA = data;
        @(negedge CORE_CLK);
        REG_WR = 1'b0;
        // released lines never keep a stale value
        REG_ADDR = ~addr;
        REG_WDATA = ~data;
    endtask : wr

    // one read, data valid the cycle after the read edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge CORE_CLK);
        REG_RD = 1'b1;
        REG_ADDR = addr;
        @(negedge CORE_CLK);
        REG_RD = 1'b0;
        REG_ADDR = ~addr;
        data = REG_RDATA;
    endtask : rd

    // connection search, reissued even with role control unchanged
    task automatic search();
        wr(ADDR_CMD, CMD_CONN_SEARCH);
    endtask : search

endmodule : pcd_mgr_model

//--- bench/testbench.sv
/*
 * testbench of the port command decoder: command, fault and
 * capability checks through the register port model.
 * assumes pcd_pkg and pcd_top compiled first.
 */
module testbench
    import pcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // clock, reset and port state
    logic core_clk;
    logic nrst;
    pcd_role_type role_ctrl;
    logic sink_active;
    logic source_at_raised;
    logic goodcrc_sent;
    // register port
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] rdv;
    // outputs packed msb first: source..error
    wire logic [7:0] outs;
    int n_mismatch;
    int num_checks;
    // search rows and expected outputs in the cycle after the action cycle
    logic [4:0] rows [6] = '{5'h15, 5'h15, 5'h05, 5'h19, 5'h1F, 5'h1A};
    logic [7:0] exps [6] = '{8'h58, 8'h58, 8'h48, 8'h48, 8'h48, 8'h50};
    logic [7:0] rsv [3] = '{CMD_RSV_C, CMD_RSV_D, CMD_RSV_E};

    pcd_top uut (
        .CORE_CLK(core_clk),
        .NRST(nrst),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata),
        .ROLE_CTRL(role_ctrl),
        .SINK_ACTIVE(sink_active),
        .SOURCE_AT_RAISED(source_at_raised),
        .GOODCRC_SENT(goodcrc_sent),
        .SOURCE_ENABLE(outs[7]),
        .VBUS_DETECT_ENABLE(outs[6]),
        .SAFE_LEVEL_RETURN(outs[5]),
        .TOGGLE_START(outs[4]),
        .TOGGLE_PULL_UP_FIRST(outs[3]),
        .RX_DETECT_CLEAR(outs[2]),
        .BUS_IDLE(outs[1]),
        .BUS_ERROR(outs[0])
    );

    pcd_mgr_model mgr (
        .CORE_CLK(core_clk),
        .REG_RDATA(reg_rdata),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata)
    );

    // 200 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // wait n falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // command write, outputs in the two cycles after the action cycle
    task automatic cmd(input logic [7:0] code, input logic [7:0] e2,
                       input logic [7:0] e3);
        mgr.wr(ADDR_CMD, code);
        cyc(1);
        chk(outs, e2);
        cyc(1);
        chk(outs, e3);
    endtask : cmd

    // verdict and end of run
    task automatic print_verdict();
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        n_mismatch = 0;
        num_checks = 0;
        nrst = 1'b0;
        role_ctrl = '0;
        sink_active = 1'b0;
        source_at_raised = 1'b0;
        goodcrc_sent = 1'b0;
        cyc(2);
        nrst = 1'b1;
        // capability fields, then a write that must not stick
        mgr.rd(ADDR_CAP, rdv);
        chk(rdv & 8'hE0, 8'hC0);
        chk(rdv & 8'h10, 8'h10);
        chk(rdv & 8'h08, 8'h08);
        chk(rdv & 8'h04, 8'h00);
        chk(rdv & 8'h02, 8'h02);
        chk(rdv & 8'h01, 8'h01);
        mgr.wr(ADDR_CAP, 8'h00);
        mgr.rd(ADDR_CAP, rdv);
        chk(rdv, 8'hDB);
        mgr.rd(ADDR_FAULT, rdv);
        chk(rdv, 8'h80);
        mgr.rd(ADDR_CMD, rdv);
        chk(rdv, 8'h00);
        mgr.rd(8'h30, rdv);
        chk(rdv, 8'h00);
        chk(outs, 8'h00);
        // safe source from raised level, return pulse once
        source_at_raised = 1'b1;
        cmd(CMD_SRC_SAFE, 8'hE0, 8'hC0);
        source_at_raised = 1'b0;
        mgr.rd(ADDR_CMD, rdv);
        chk(rdv, 8'h00);
        cmd(CMD_STOP_SRC, 8'h40, 8'h40);
        // safe source refused while sinking, error latched
        sink_active = 1'b1;
        cmd(CMD_SRC_SAFE, 8'h41, 8'h41);
        sink_active = 1'b0;
        cyc(4);
        chk(outs, 8'h41);
        mgr.wr(ADDR_FAULT, 8'h01);
        chk(outs, 8'h40);
        mgr.rd(ADDR_FAULT, rdv);
        chk(rdv, 8'h80);
        cmd(CMD_SRC_RAISED, 8'h41, 8'h41);
        mgr.wr(ADDR_FAULT, 8'h01);
        // search over the role table
        for (int i = 0; i < 6; i++)
        begin
            role_ctrl = rows[i];
            mgr.search();
            cyc(1);
            chk(outs, exps[i]);
            cyc(1);
            chk(outs, exps[i] & 8'hEF);
        end
        // final receive: ack in the action cycle is ignored
        mgr.wr(ADDR_CMD, CMD_FINAL_RX);
        goodcrc_sent = 1'b1;
        cyc(1);
        goodcrc_sent = 1'b0;
        chk(outs, 8'h40);
        cyc(1);
        goodcrc_sent = 1'b1;
        cyc(1);
        goodcrc_sent = 1'b0;
        chk(outs, 8'h44);
        cyc(1);
        chk(outs, 8'h40);
        // ack in the first armed cycle counts
        mgr.wr(ADDR_CMD, CMD_FINAL_RX);
        cyc(1);
        goodcrc_sent = 1'b1;
        cyc(1);
        goodcrc_sent = 1'b0;
        chk(outs, 8'h44);
        cyc(1);
        chk(outs, 8'h40);
        // disarmed now: a further ack clears nothing
        goodcrc_sent = 1'b1;
        cyc(1);
        goodcrc_sent = 1'b0;
        cyc(1);
        chk(outs, 8'h40);
        foreach (rsv[i]) cmd(rsv[i], 8'h40, 8'h40);
        // idle, woken by the next access
        cmd(CMD_BUS_IDLE, 8'h42, 8'h42);
        mgr.rd(ADDR_CMD, rdv);
        chk(rdv, 8'h00);
        cyc(1);
        chk(outs, 8'h40);
        // power-on flag clears on write one
        mgr.wr(ADDR_FAULT, 8'h80);
        mgr.rd(ADDR_FAULT, rdv);
        chk(rdv, 8'h00);
        print_verdict();
    end

    // watchdog, far beyond the hundred or so cycles needed
    initial
    begin
        #20000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end

endmodule : testbench

//--- hdl/pcd_cap.sv
/*
 * read-only capability register of the port command decoder.
 * assumes the parent registers the read data; output is constant.
 */
module pcd_cap
    import pcd_pkg::*;
(
    // capability fields
    output pcd_pkg::pcd_cap_type CAP
);
    // fixed capability word
    always_comb
    begin
        CAP.roles = CAP_ROLES;
        CAP.packet_type_support_bit = CAP_PACKET_ALL;
        CAP.vconn_switch_capable = CAP_VCONN_SW;
        CAP.sink_path_capable = CAP_SINK_PATH;
        CAP.raised_source_capable = CAP_RAISED_SRC;
        CAP.source_safe_capable = CAP_SAFE_SRC;
    end
endmodule : pcd_cap

//--- hdl/pcd_pkg.sv
/*
 * shared constants and types of the port command decoder:
 * register addresses, command byte codes, fault bit positions,
 * capability layout, role-control carrier and decoder states.
 * assumes one clock domain and an 8-bit register access port.
 */
package pcd_pkg;

    // register addresses on the internal register port
    localparam logic [7:0] ADDR_FAULT = 8'h1F;
    localparam logic [7:0] ADDR_CMD = 8'h23;
    localparam logic [7:0] ADDR_CAP = 8'h24;

    // command byte codes handled here
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_STOP_SRC = 8'h66;
    localparam logic [7:0] CMD_SRC_SAFE = 8'h77;
    localparam logic [7:0] CMD_SRC_RAISED = 8'h88;
    localparam logic [7:0] CMD_CONN_SEARCH = 8'h99;
    localparam logic [7:0] CMD_FINAL_RX = 8'hAA;
    localparam logic [7:0] CMD_RSV_C = 8'hCC;
    localparam logic [7:0] CMD_RSV_D = 8'hDD;
    localparam logic [7:0] CMD_RSV_E = 8'hEE;
    localparam logic [7:0] CMD_BUS_IDLE = 8'hFF;

    // fault status register layout
    localparam int FLT_BUS_ERR_BIT = 0;
    localparam int FLT_ALL_RESET_BIT = 7;
    localparam logic [7:0] FAULT_RESET = 8'h80;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // termination field codes
    localparam logic [1:0] CC_PULL_UP = 2'h1;
    localparam logic [1:0] CC_PULL_DOWN = 2'h2;

    // capability field values
    localparam logic [2:0] CAP_ROLES = 3'h6;
    localparam logic CAP_PACKET_ALL = 1'h1;
    localparam logic CAP_VCONN_SW = 1'h1;
    localparam logic CAP_SINK_PATH = 1'h0;
    localparam logic CAP_RAISED_SRC = 1'h1;
    localparam logic CAP_SAFE_SRC = 1'h1;
    localparam logic [7:0] CAP_RESET = 8'hDB;

    // role control settings seen by the decoder
    typedef struct packed {
        logic dual_role_enable;
        logic [1:0] cc2;
        logic [1:0] cc1;
    } pcd_role_type;

    // capability register fields, msb first
    typedef struct packed {
        logic [2:0] roles;
        logic packet_type_support_bit;
        logic vconn_switch_capable;
        logic sink_path_capable;
        logic raised_source_capable;
        logic source_safe_capable;
    } pcd_cap_type;

    // decoder states, gray along idle to execute
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1
    } pcd_state_type;

endpackage : pcd_pkg

//--- hdl/pcd_top.sv
/*
 * port command decoder: command byte, fault status and capability
 * registers, and the upper command actions of the port controller.
 * assumes the serial front end delivers single-cycle register
 * writes and reads on CORE_CLK, and that role control, sink state,
 * raised-level state and the receiver's acknowledge event come from
 * logic on the same clock.
 */
// Notes on behaviour
// - stop source, keep presence detection running
// - safe source on, presence detection on
// - safe command from raised level returns to safe
// - safe command while sinking is refused, error set
// - raised source command always refused, error set
// - search starts toggling only with dual role
// - toggling starts pull-up on 01, pull-down 10
// - mismatched termination fields block toggling
// - final receive clears receive enables after ack
// - reserved codes take no action
// - idle command puts serial interface idle
// - capability roles read source, sink, dual
// - capability bit four reports all packet types
// - capability bit three reports power switch
// - capability bit two reports sink path
// - capability bit one reports raised source
// - capability bit zero reports safe source
// - command byte resets zero, clears after use
// - bus error latches, write one clears
module pcd_top
    import pcd_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // port state inputs
    input wire pcd_pkg::pcd_role_type ROLE_CTRL,
    input wire logic SINK_ACTIVE,
    input wire logic SOURCE_AT_RAISED,
    input wire logic GOODCRC_SENT,
    // power path controls
    output logic SOURCE_ENABLE,
    output logic VBUS_DETECT_ENABLE,
    output logic SAFE_LEVEL_RETURN,
    // connection search controls
    output logic TOGGLE_START,
    output logic TOGGLE_PULL_UP_FIRST,
    // receiver and interface controls
    output logic RX_DETECT_CLEAR,
    output logic BUS_IDLE,
    output logic BUS_ERROR
);
    import pcd_pkg::*;

    // termination pair test, used for both start polarities
    function automatic logic cc_pair(input pcd_role_type r,
                                     input logic [1:0] code);
        cc_pair = (r.cc1 == code) && (r.cc2 == code);
    endfunction : cc_pair

    // decoder state and command byte
    pcd_state_type state_r;
    pcd_state_type state_nxt;
    logic [7:0] cmd_r;          // command byte as written
    logic [7:0] cmd_nxt;
    // fault status byte
    logic [7:0] fault_r;
    logic [7:0] fault_nxt;
    // power path state
    logic src_en_r;
    logic det_en_r;
    logic safe_ret_r;
    // toggling state
    logic tog_start_r;
    logic tog_pu_r;
    // receiver arm and interface idle
    logic armed_r;
    logic rx_clr_r;
    logic idle_r;
    // read data
    logic [7:0] rdata_r;
    // capability word
    pcd_cap_type cap;

    // access decodes
    logic wr_cmd;               // write to command byte
    logic wr_fault;             // write to fault status
    logic exec;                 // one action cycle per write
    logic act_stop;
    logic act_safe;
    logic act_raised;
    logic act_search;
    logic act_final;
    logic act_idle;
    logic refuse_safe;          // safe request while sinking
    logic err_set;              // bus error event
    logic tog_ok_pu;
    logic tog_ok_pd;

    // capability register
    pcd_cap u_cap (
        .CAP (cap)
    );

    // decode of writes and of the command being executed
    always_comb
    begin
        wr_cmd = REG_WR && (REG_ADDR == ADDR_CMD);
        wr_fault = REG_WR && (REG_ADDR == ADDR_FAULT);
        exec = (state_r == ST_EXEC);
        act_stop = exec && (cmd_r == CMD_STOP_SRC);
        act_safe = exec && (cmd_r == CMD_SRC_SAFE);
        act_raised = exec && (cmd_r == CMD_SRC_RAISED);
        act_search = exec && (cmd_r == CMD_CONN_SEARCH);
        act_final = exec && (cmd_r == CMD_FINAL_RX);
        act_idle = exec && (cmd_r == CMD_BUS_IDLE);
        refuse_safe = act_safe && SINK_ACTIVE;
        err_set = refuse_safe || act_raised;
        // toggling needs dual role and a matching pair
        tog_ok_pu = act_search && ROLE_CTRL.dual_role_enable
                    && cc_pair(ROLE_CTRL, CC_PULL_UP);
        tog_ok_pd = act_search && ROLE_CTRL.dual_role_enable
                    && cc_pair(ROLE_CTRL, CC_PULL_DOWN);
    end

    // next state and command byte
    always_comb
    begin
        // a write arms one action cycle
        state_nxt = wr_cmd ? ST_EXEC : ST_IDLE;
        cmd_nxt = cmd_r;
        if (wr_cmd)
        begin
            // new command; reserved codes decode to nothing
            cmd_nxt = REG_WDATA;
        end
        else if (exec)
        begin
            // auto clear once the action is taken
            cmd_nxt = CMD_NONE;
        end
    end

    // decoder state register
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // command byte register
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cmd_r <= CMD_NONE;
        end
        else
        begin
            cmd_r <= cmd_nxt;
        end
    end

    // fault status: set wins over write-one-to-clear
    always_comb
    begin
        fault_nxt = fault_r;
        if (wr_fault)
        begin
            // clear only the bits written as one
            fault_nxt = fault_r & ~REG_WDATA;
        end
        if (err_set)
        begin
            fault_nxt[FLT_BUS_ERR_BIT] = 1'b1;
        end
        // unused bits always read zero
        fault_nxt = fault_nxt & ((8'h1 << FLT_BUS_ERR_BIT)
                                 | (8'h1 << FLT_ALL_RESET_BIT));
    end

    // fault status register
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            fault_r <= FAULT_RESET;
        end
        else
        begin
            fault_r <= fault_nxt;
        end
    end

    // source path enable and presence detection
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            src_en_r <= 1'b0;
            det_en_r <= 1'b0;
        end
        else if (act_stop)
        begin
            // detection left as it was
            src_en_r <= 1'b0;
        end
        else if (act_safe && !SINK_ACTIVE)
        begin
            src_en_r <= 1'b1;
            det_en_r <= 1'b1;
        end
    end

    // one-cycle request to drop back to the safe level
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            safe_ret_r <= 1'b0;
        end
        else
        begin
            safe_ret_r <= act_safe && !SINK_ACTIVE
                          && SOURCE_AT_RAISED;
        end
    end

    // toggling start pulse and first termination
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tog_start_r <= 1'b0;
            tog_pu_r <= 1'b0;
        end
        else
        begin
            tog_start_r <= tog_ok_pu || tog_ok_pd;
            if (tog_ok_pu || tog_ok_pd)
            begin
                tog_pu_r <= tog_ok_pu;
            end
        end
    end

    // final receive arm, released by the next acknowledge
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            armed_r <= 1'b0;
            rx_clr_r <= 1'b0;
        end
        else
        begin
            rx_clr_r <= armed_r && GOODCRC_SENT;
            if (act_final)
            begin
                // arming wins over a same-cycle acknowledge
                armed_r <= 1'b1;
            end
            else if (GOODCRC_SENT)
            begin
                armed_r <= 1'b0;
            end
        end
    end

    // serial interface idle, woken by any register access
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            idle_r <= 1'b0;
        end
        else if (act_idle)
        begin
            idle_r <= 1'b1;
        end
        else if (REG_WR || REG_RD)
        begin
            idle_r <= 1'b0;
        end
    end

    // registered read data, unmapped reads return zero
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rdata_r <= READ_ZERO;
        end
        else if (REG_RD)
        begin
            case (REG_ADDR)
                ADDR_FAULT: rdata_r <= fault_r;
                ADDR_CMD: rdata_r <= cmd_r;
                ADDR_CAP: rdata_r <= cap;
                default: rdata_r <= READ_ZERO;
            endcase
        end
    end

    // output drive
    assign REG_RDATA = rdata_r;
    assign SOURCE_ENABLE = src_en_r;
    assign VBUS_DETECT_ENABLE = det_en_r;
    assign SAFE_LEVEL_RETURN = safe_ret_r;
    assign TOGGLE_START = tog_start_r;
    assign TOGGLE_PULL_UP_FIRST = tog_pu_r;
    assign RX_DETECT_CLEAR = rx_clr_r;
    assign BUS_IDLE = idle_r;
    assign BUS_ERROR = fault_r[FLT_BUS_ERR_BIT];

    // stop command drops source, detection unchanged
    property p_stop_src;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_stop |=> !SOURCE_ENABLE
                     && $stable(VBUS_DETECT_ENABLE);
    endproperty
    a_stop_src: assert property (p_stop_src)
        else $error("source not stopped");

    // safe command enables source and detection
    property p_src_safe;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_safe && !SINK_ACTIVE |=> SOURCE_ENABLE
                                     && VBUS_DETECT_ENABLE;
    endproperty
    a_src_safe: assert property (p_src_safe)
        else $error("safe source not enabled");

    // raised level returns to safe level
    property p_safe_ret;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_safe && !SINK_ACTIVE && SOURCE_AT_RAISED
            |=> SAFE_LEVEL_RETURN ##1 !SAFE_LEVEL_RETURN;
    endproperty
    a_safe_ret: assert property (p_safe_ret)
        else $error("no return to safe level");

    // safe command refused while sinking
    property p_sink_refuse;
        @(posedge CORE_CLK) disable iff (!NRST)
        refuse_safe |=> BUS_ERROR && $stable(SOURCE_ENABLE)
                        && !SAFE_LEVEL_RETURN;
    endproperty
    a_sink_refuse: assert property (p_sink_refuse)
        else $error("safe command not refused");

    // raised command refused
    property p_raised;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_raised |=> BUS_ERROR && $stable(SOURCE_ENABLE)
                       && $stable(VBUS_DETECT_ENABLE);
    endproperty
    a_raised: assert property (p_raised)
        else $error("raised command not refused");

    // toggling only after search with dual role
    property p_toggle_gate;
        @(posedge CORE_CLK) disable iff (!NRST)
        TOGGLE_START |-> $past(act_search)
                         && $past(ROLE_CTRL.dual_role_enable);
    endproperty
    a_toggle_gate: assert property (p_toggle_gate)
        else $error("toggling without dual role search");

    // first termination follows the field pair
    property p_toggle_pu;
        @(posedge CORE_CLK) disable iff (!NRST)
        TOGGLE_START |-> TOGGLE_PULL_UP_FIRST
                         == ($past(ROLE_CTRL.cc1) == CC_PULL_UP);
    endproperty
    a_toggle_pu: assert property (p_toggle_pu)
        else $error("wrong first termination");

    // mismatched fields block toggling
    property p_no_toggle;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_search && !cc_pair(ROLE_CTRL, CC_PULL_UP)
            && !cc_pair(ROLE_CTRL, CC_PULL_DOWN) |=> !TOGGLE_START;
    endproperty
    a_no_toggle: assert property (p_no_toggle)
        else $error("toggling on mismatched fields");

    // armed receiver clears enables after next acknowledge
    property p_rx_clear;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_final ##1 GOODCRC_SENT |=> RX_DETECT_CLEAR
                                      ##1 !RX_DETECT_CLEAR;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("receive enables not cleared");

    // reserved codes leave source, error, toggling and safe return alone
    property p_reserved;
        @(posedge CORE_CLK) disable iff (!NRST)
        exec && (cmd_r == CMD_RSV_C || cmd_r == CMD_RSV_D
                 || cmd_r == CMD_RSV_E)
            |=> $stable(SOURCE_ENABLE) && !TOGGLE_START
                && $stable(BUS_ERROR) && !SAFE_LEVEL_RETURN;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code acted");

    // idle command reaches the interface
    property p_idle;
        @(posedge CORE_CLK) disable iff (!NRST)
        act_idle |=> BUS_IDLE;
    endproperty
    a_idle: assert property (p_idle)
        else $error("interface not idle");

    // capability read returns the fixed word
    property p_cap;
        @(posedge CORE_CLK) disable iff (!NRST)
        REG_RD && REG_ADDR == ADDR_CAP |=> REG_RDATA == CAP_RESET;
    endproperty
    a_cap: assert property (p_cap)
        else $error("capability word wrong");

    // command byte clears two cycles after a lone write
    property p_cmd_clear;
        @(posedge CORE_CLK) disable iff (!NRST)
        wr_cmd ##1 !wr_cmd |=> cmd_r == CMD_NONE && !exec;
    endproperty
    a_cmd_clear: assert property (p_cmd_clear)
        else $error("command byte not cleared");

    // bus error holds until written with one
    property p_fault_latch;
        @(posedge CORE_CLK) disable iff (!NRST)
        BUS_ERROR && !(wr_fault && REG_WDATA[FLT_BUS_ERR_BIT])
            |=> BUS_ERROR;
    endproperty
    a_fault_latch: assert property (p_fault_latch)
        else $error("bus error lost");

    // one action cycle per write
    property p_once;
        @(posedge CORE_CLK) disable iff (!NRST)
        exec && !$past(wr_cmd) |-> 1'b0;
    endproperty
    a_once: assert property (p_once)
        else $error("command acted twice");

endmodule : pcd_top
